//--- hdl/nsc_status_command_regs.sv
// Status and command register pair with APB slave and soft reset sequencing
//
// Added by the designer: the register addresses and the APB register port.
`default_nettype none
module nsc_status_command_regs #(
  parameter int RESET_CYCLES = nsc_pkg::NSC_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [nsc_pkg::NSC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_permit,
  input wire nsc_pkg::nsc_events_t events,
  output logic run_active,
  output logic power_q_permit,
  output logic clock_q_permit,
  output logic clock_gate_enable,
  output logic processing_halted,
  output logic ram_clear
);
  import nsc_pkg::*;

  initial begin
    if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin
      $error("RESET_CYCLES must lie in 1..255");
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic srst;
  logic soft_go_reg;
  logic reset_busy_reg;
  logic [7:0] rst_cnt_reg;
  logic hit_status;
  logic hit_cmd;
  logic hit_reset;
  logic hit_queue;
  logic mapped;
  logic wr_cmd;
  logic wr_reset;
  logic wr_queue;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign srst = reset || soft_go_reg;
  assign hit_status = (paddr == NSC_OFS_STATUS);
  assign hit_cmd = (paddr == NSC_OFS_CMD);
  assign hit_reset = (paddr == NSC_OFS_RESET);
  assign hit_queue = (paddr == NSC_OFS_QSTART0) || (paddr == NSC_OFS_QSTART1) || (paddr == NSC_OFS_QLEN);
  assign mapped = hit_status || hit_cmd || hit_reset || hit_queue;
  // Writes other than to status are dropped while reset is in progress
  assign wr_cmd = access && pwrite && hit_cmd && !reset_busy_reg; // RULE10
  assign wr_reset = access && pwrite && hit_reset && !reset_busy_reg && reset_permit; // RULE19
  assign wr_queue = access && pwrite && hit_queue && !reset_busy_reg;

  // ----------------------------------------------------------------
  // Reset sequencing
  // ----------------------------------------------------------------
  // A refused reset request is simply ignored; no error is flagged
  always_ff @(posedge clk) begin
    if (reset) begin
      soft_go_reg <= 1'b0;
    end else begin
      soft_go_reg <= wr_reset; // RULE19
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ram_clear <= 1'b0;
    end else begin
      ram_clear <= wr_reset; // RULE19
    end
  end

  // The flag comes up set and drops after a fixed settling count
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_busy_reg <= 1'b1;
      rst_cnt_reg <= 8'h00;
    end else if (reset_busy_reg) begin
      if (rst_cnt_reg == 8'(RESET_CYCLES - 1)) begin
        reset_busy_reg <= 1'b0;
      end
      rst_cnt_reg <= rst_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Command word
  // ----------------------------------------------------------------
  logic [31:0] cmd_reg;
  logic ack;
  logic launch;

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_reg <= NSC_CMD_RESET;
    end else if (wr_cmd) begin
      cmd_reg <= pwdata & NSC_CMD_KEEP; // RULE14
    end
  end

  assign ack = wr_cmd && pwdata[NSC_CMD_ACK]; // RULE17
  assign launch = wr_cmd && pwdata[NSC_CMD_LAUNCH]; // RULE18

  always_ff @(posedge clk) begin
    if (srst) begin
      power_q_permit <= 1'b1;
      clock_q_permit <= 1'b1;
      clock_gate_enable <= 1'b1;
    end else if (wr_cmd) begin
      power_q_permit <= pwdata[NSC_CMD_PWRQ]; // RULE15
      clock_q_permit <= pwdata[NSC_CMD_CLKQ]; // RULE16
      clock_gate_enable <= pwdata[NSC_CMD_CLKQ]; // RULE16
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic irq_flag;
  logic pmu_flag;
  logic end_flag;
  logic parse_flag;
  logic ecc_flag;
  logic bus_flag;
  logic [15:0] hist_reg;
  logic [3:0] stream_reg;
  logic port_reg;
  logic state_reg;

  nsc_sticky_flag u_irq (
    .clk(clk),
    .rst(srst),
    .set(events.irq), // RULE12
    .clr(ack), // RULE17
    .q(irq_flag)
  );

  nsc_sticky_flag u_pmu (
    .clk(clk),
    .rst(srst),
    .set(events.pmu_irq), // RULE7
    .clr(ack), // RULE17
    .q(pmu_flag)
  );

  nsc_sticky_flag u_end (
    .clk(clk),
    .rst(srst),
    .set(events.queue_end),
    .clr(wr_queue && !state_reg), // RULE8
    .q(end_flag)
  );

  nsc_sticky_flag u_parse (
    .clk(clk),
    .rst(srst),
    .set(events.parse_error), // RULE9
    .clr(1'b0),
    .q(parse_flag)
  );

  nsc_sticky_flag u_ecc (
    .clk(clk),
    .rst(srst),
    .set(events.ecc_fault), // RULE5
    .clr(1'b0),
    .q(ecc_flag)
  );

  nsc_sticky_flag u_bus (
    .clk(clk),
    .rst(srst),
    .set(events.bus_abort), // RULE11
    .clr(1'b0),
    .q(bus_flag)
  );

  // New mask bits win over a wipe of the same bit in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      hist_reg <= 16'h0000;
    end else begin
      hist_reg <= (hist_reg & ~(wr_cmd ? pwdata[31:16] : 16'h0000)) // RULE2
        | (events.hist_valid ? events.hist_mask : 16'h0000); // RULE1
    end
  end

  // Only the first abort is recorded; later ones must not overwrite it
  always_ff @(posedge clk) begin
    if (srst) begin
      stream_reg <= 4'h0;
      port_reg <= 1'b0;
    end else if (events.bus_abort && !bus_flag) begin
      stream_reg <= events.abort_stream; // RULE3 RULE20
      port_reg <= events.abort_port; // RULE4 RULE20
    end
  end

  // Stopping has priority; a halted unit refuses to launch
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= 1'b0;
    end else if (events.bus_abort || bus_flag) begin
      state_reg <= 1'b0; // RULE11
    end else if (events.queue_end || events.parse_error) begin
      state_reg <= 1'b0;
    end else if (launch) begin
      state_reg <= 1'b1; // RULE18 RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      run_active <= 1'b0;
      processing_halted <= 1'b0;
    end else begin
      run_active <= state_reg;
      processing_halted <= bus_flag; // RULE11
    end
  end

  logic [31:0] status_word;
  assign status_word = {hist_reg, stream_reg, port_reg, 2'b00, ecc_flag,
    1'b0, pmu_flag, end_flag, parse_flag, reset_busy_reg, bus_flag, irq_flag, state_reg}; // RULE6 RULE13

  // ----------------------------------------------------------------
  // Read data and handshake
  // ----------------------------------------------------------------
  // Data is captured in the setup cycle so prdata leaves a flip-flop
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      if (hit_status) begin
        prdata <= status_word;
      end else if (hit_cmd && !reset_busy_reg) begin
        prdata <= cmd_reg; // RULE14
      end else begin
        prdata <= 32'h00000000; // RULE10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_hist_or;
    events.hist_valid && !srst |=> (hist_reg & $past(events.hist_mask)) == $past(events.hist_mask);
  endproperty
  a_hist_or: assert property (p_hist_or) else $error("history mask not merged"); // RULE1

  property p_hist_wipe;
    wr_cmd && !events.hist_valid && !srst |=> (hist_reg & $past(pwdata[31:16])) == 16'h0000;
  endproperty
  a_hist_wipe: assert property (p_hist_wipe) else $error("history wipe failed"); // RULE2

  property p_abort_fields;
    events.bus_abort && !bus_flag && !srst
      |=> bus_flag && stream_reg == $past(events.abort_stream) && port_reg == $past(events.abort_port);
  endproperty
  a_abort_fields: assert property (p_abort_fields) else $error("abort fields not captured"); // RULE3

  property p_abort_hold;
    bus_flag && !srst |=> $stable(stream_reg) && $stable(port_reg);
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("abort fields changed"); // RULE20

  property p_port_bit;
    access && !pwrite && hit_status |-> prdata[11] == $past(port_reg);
  endproperty
  a_port_bit: assert property (p_port_bit) else $error("port bit misplaced"); // RULE4

  property p_sticky_errors;
    ecc_flag && !srst |=> ecc_flag;
  endproperty
  a_sticky_errors: assert property (p_sticky_errors) else $error("error flag lost"); // RULE5

  property p_parse_hold;
    parse_flag && !srst |=> parse_flag;
  endproperty
  a_parse_hold: assert property (p_parse_hold) else $error("parse flag cleared"); // RULE9

  property p_unused_zero;
    access && !pwrite && hit_status |-> !prdata[7];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused timer flag set"); // RULE6

  property p_pmu_set;
    events.pmu_irq && !srst |=> pmu_flag;
  endproperty
  a_pmu_set: assert property (p_pmu_set) else $error("pmu flag missed"); // RULE7

  property p_end_clear;
    $fell(end_flag) |-> $past(srst) || ($past(wr_queue) && !$past(state_reg));
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("queue end flag cleared wrongly"); // RULE8

  property p_busy_read;
    setup && !pwrite && !hit_status && reset_busy_reg |=> prdata == 32'h00000000;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("read during reset not zero"); // RULE10

  property p_halt_stop;
    bus_flag |-> !state_reg ##1 processing_halted || $past(srst) || srst;
  endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("halted unit still running"); // RULE11

  property p_ack_clear;
    ack && !events.irq && !events.pmu_irq && !srst |=> !irq_flag && !pmu_flag;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear"); // RULE17

  property p_irq_set;
    events.irq && !srst |=> irq_flag ##1 (irq_flag || $past(ack) || $past(srst));
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("raw irq not held"); // RULE12

  property p_launch;
    launch && !bus_flag && !events.bus_abort && !events.queue_end && !events.parse_error && !srst
      |=> state_reg ##1 run_active;
  endproperty
  a_launch: assert property (p_launch) else $error("launch ignored"); // RULE18

  property p_cmd_read;
    wr_cmd && !srst ##1 (!wr_cmd && !srst) ##1 (setup && !pwrite && hit_cmd && !srst)
      |=> prdata == ($past(pwdata, 3) & NSC_CMD_KEEP);
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command readback wrong"); // RULE14

  property p_quiesce;
    wr_cmd && !srst |=> power_q_permit == $past(pwdata[3]) && clock_gate_enable == $past(pwdata[2]);
  endproperty
  a_quiesce: assert property (p_quiesce) else $error("quiescence bits wrong"); // RULE15

  property p_state_bit;
    access && !pwrite && hit_status |-> prdata[0] == $past(state_reg);
  endproperty
  a_state_bit: assert property (p_state_bit) else $error("state bit wrong"); // RULE13

  property p_soft_reset;
    wr_reset |=> ram_clear && soft_go_reg ##1 reset_busy_reg && !state_reg;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not taken"); // RULE19

  property p_clock_gate;
    clock_q_permit == clock_gate_enable;
  endproperty
  a_clock_gate: assert property (p_clock_gate) else $error("clock gate mismatch"); // RULE16

  c_launch: cover property (launch ##[1:20] events.queue_end);
  c_abort: cover property (events.bus_abort && !bus_flag);
  c_soft_reset: cover property (wr_reset ##[1:40] !reset_busy_reg);
endmodule
`default_nettype wire

//--- hdl/nsc_pkg.sv
// Constants and carrier types for the status and command register pair
// Contract
// RULE1: OR each event mask into history log
// RULE2: Command wipe field clears matching history bits
// RULE3: Abort reports offending stream code
// RULE4: Abort records faulting manager port bit
// RULE5: RAM error flag sticky until reset
// RULE6: Unused timer flag always reads zero
// RULE7: Perf interrupt flag set; acknowledge clears
// RULE8: Queue end cleared by queue write stopped
// RULE9: Decode error flag sticky until reset
// RULE10: During reset only status readable
// RULE11: Abort halts unit until reset
// RULE12: Raw interrupt flag set; acknowledge clears
// RULE13: Lowest status bit shows run state
// RULE14: Command word reads last written value; the code keeps only bits 31:16 and 3:0 of it, the other bits read zero
// RULE15: Bit 3 permits power quiescence
// RULE16: Bit 2 permits clock stop, gate
// RULE17: Acknowledge bit clears interrupt flags
// RULE18: Launch bit starts running state
// RULE19: Permitted reset request resets unit
// RULE20: Abort fields captured with halt flag
`default_nettype none
package nsc_pkg;
  localparam int NSC_AW = 12;
  localparam logic [NSC_AW-1:0] NSC_OFS_STATUS = 12'h004;
  localparam logic [NSC_AW-1:0] NSC_OFS_CMD = 12'h008;
  localparam logic [NSC_AW-1:0] NSC_OFS_RESET = 12'h00c;
  localparam logic [NSC_AW-1:0] NSC_OFS_QSTART0 = 12'h010;
  localparam logic [NSC_AW-1:0] NSC_OFS_QSTART1 = 12'h014;
  localparam logic [NSC_AW-1:0] NSC_OFS_QLEN = 12'h020;
  localparam logic [31:0] NSC_CMD_RESET = 32'h0000000c;
  localparam logic [31:0] NSC_CMD_KEEP = 32'hffff000f;
  localparam int NSC_CMD_LAUNCH = 0;
  localparam int NSC_CMD_ACK = 1;
  localparam int NSC_CMD_CLKQ = 2;
  localparam int NSC_CMD_PWRQ = 3;
  localparam int NSC_RESET_CYCLES = 16;
  localparam logic [3:0] NSC_RD_CMD = 4'h0;
  localparam logic [3:0] NSC_RD_INPUT_FEATURE = 4'h1;
  localparam logic [3:0] NSC_RD_WEIGHT = 4'h2;
  localparam logic [3:0] NSC_RD_SCALE_BIAS = 4'h3;
  localparam logic [3:0] NSC_RD_MEMORY_COPY = 4'h4;
  localparam logic [3:0] NSC_WR_OUTPUT_FEATURE = 4'h8;
  localparam logic [3:0] NSC_WR_MEMORY_COPY = 4'h9;

  typedef struct packed {
    logic hist_valid;
    logic [15:0] hist_mask;
    logic irq;
    logic pmu_irq;
    logic queue_end;
    logic parse_error;
    logic ecc_fault;
    logic bus_abort;
    logic [3:0] abort_stream;
    logic abort_port;
  } nsc_events_t;
endpackage
`default_nettype wire

//--- hdl/nsc_sticky_flag.sv
// Sticky status flag where a set always beats a clear
`default_nettype none
module nsc_sticky_flag (
  input wire logic clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the status and command register pair
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import nsc_pkg::*;
  logic clk, reset, psel, penable, pwrite, reset_permit, err;
  logic [NSC_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, run_active, power_q_permit, clock_q_permit;
  logic clock_gate_enable, processing_halted, ram_clear;
  nsc_events_t events;
  int n_fail = 0;
  int check_count = 0;
  int clr_seen = 0;

  // Short reset window keeps the run brief; the in-reset cmd checks of s_reset need it to be at least 8 cycles
  nsc_status_command_regs #(.RESET_CYCLES(8)) u_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_permit(reset_permit), .events(events), .run_active(run_active),
    .power_q_permit(power_q_permit), .clock_q_permit(clock_q_permit),
    .clock_gate_enable(clock_gate_enable), .processing_halted(processing_halted),
    .ram_clear(ram_clear)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ram_clear === 1'b1) clr_seen++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Holds the request until pready is seen high, then releases it and lets one idle edge pass
  task automatic apb(input logic wr, input logic [NSC_AW-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input nsc_events_t e);
    events <= e;
    @(posedge clk);
    events <= '0;
    @(posedge clk);
  endtask

  task automatic hard_reset;
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h8;
    while (rd[3] !== 1'b0 && n < 20) begin
      apb(1'b0, NSC_OFS_STATUS, 32'h0);
      n++;
    end
    chk({31'h0, rd[3]}, 32'h0, "reset flag stuck");
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset;
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h8, "status in reset");
    apb(1'b1, NSC_OFS_CMD, 32'h0);
    apb(1'b0, NSC_OFS_CMD, 32'h0);
    chk(rd, 32'h0, "cmd read in reset");
    wait_idle();
    chk(rd, 32'h0, "status idle");
    apb(1'b0, NSC_OFS_CMD, 32'h0);
    chk(rd, 32'h0000000c, "cmd reset value");
    chk({29'h0, power_q_permit, clock_q_permit, clock_gate_enable}, 32'h7, "permits");
  endtask

  task automatic s_cmd;
    apb(1'b1, NSC_OFS_CMD, 32'hfffffff0);
    apb(1'b0, NSC_OFS_CMD, 32'h0);
    chk(rd, 32'hffff0000, "cmd readback");
    chk({31'h0, err}, 32'h0, "mapped read error");
    chk({29'h0, power_q_permit, clock_q_permit, clock_gate_enable}, 32'h0, "permits off");
    apb(1'b1, NSC_OFS_CMD, 32'h0000000c);
    chk({29'h0, power_q_permit, clock_q_permit, clock_gate_enable}, 32'h7, "permits on");
    apb(1'b0, 12'h100, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
  endtask

  task automatic s_hist;
    nsc_events_t e;
    e = '0;
    e.hist_valid = 1'b1;
    e.hist_mask = 16'h00a5;
    pulse(e);
    e.hist_mask = 16'h5a00;
    pulse(e);
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h5aa50000, "history or");
    apb(1'b1, NSC_OFS_CMD, 32'h000f000c);
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h5aa00000, "history wipe");
  endtask

  task automatic s_irq;
    nsc_events_t e;
    e = '0;
    e.irq = 1'b1;
    e.pmu_irq = 1'b1;
    pulse(e);
    apb(1'b1, NSC_OFS_CMD, 32'h0000000c);
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h5aa00042, "irq flags held");
    apb(1'b1, NSC_OFS_CMD, 32'h0000000e);
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h5aa00000, "irq acked");
  endtask

  task automatic s_run;
    nsc_events_t e;
    apb(1'b1, NSC_OFS_CMD, 32'h0000000d);
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h5aa00001, "launch");
    chk({31'h0, run_active}, 32'h1, "run output");
    e = '0;
    e.queue_end = 1'b1;
    pulse(e);
    apb(1'b1, NSC_OFS_CMD, 32'h0000000d);
    apb(1'b1, NSC_OFS_QSTART0, 32'h0);
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h5aa00021, "queue end kept while running");
    e = '0;
    e.parse_error = 1'b1;
    pulse(e);
    apb(1'b1, NSC_OFS_CMD, 32'h0000000e);
    apb(1'b1, NSC_OFS_QLEN, 32'h0);
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h5aa00010, "queue end cleared, parse kept");
  endtask

  // Every stream code, alternating ports; a second abort must not overwrite the first
  task automatic s_abort;
    nsc_events_t e;
    logic [3:0] codes [7];
    codes = '{NSC_RD_CMD, NSC_RD_INPUT_FEATURE, NSC_RD_WEIGHT, NSC_RD_SCALE_BIAS,
              NSC_RD_MEMORY_COPY, NSC_WR_OUTPUT_FEATURE, NSC_WR_MEMORY_COPY};
    for (int i = 0; i < 7; i++) begin
      hard_reset();
      wait_idle();
      e = '0;
      e.bus_abort = 1'b1;
      e.ecc_fault = 1'b1;
      e.abort_stream = codes[i];
      e.abort_port = i[0];
      pulse(e);
      e.ecc_fault = 1'b0;
      e.abort_stream = codes[(i + 1) % 7];
      e.abort_port = ~i[0];
      pulse(e);
      apb(1'b1, NSC_OFS_CMD, 32'h0000000d);
      apb(1'b1, NSC_OFS_CMD, 32'h0000000e);
      apb(1'b0, NSC_OFS_STATUS, 32'h0);
      chk(rd, {16'h0, codes[i], i[0], 3'b001, 8'h04}, "abort status");
      chk({30'h0, processing_halted, run_active}, 32'h2, "halted");
    end
  endtask

  task automatic s_soft;
    reset_permit <= 1'b0;
    apb(1'b1, NSC_OFS_RESET, 32'h0);
    repeat (3) @(posedge clk);
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(clr_seen, 32'h0, "refused reset cleared ram");
    chk(rd[15:0], 16'h9104, "refused reset changed state");
    reset_permit <= 1'b1;
    apb(1'b1, NSC_OFS_RESET, 32'h0);
    repeat (2) @(posedge clk);
    chk(clr_seen, 32'h1, "ram clear pulse");
    apb(1'b0, NSC_OFS_STATUS, 32'h0);
    chk(rd, 32'h8, "soft reset status");
    wait_idle();
    chk(rd, 32'h0, "flags cleared by reset");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    reset_permit = 1'b0;
    events = '0;
    hard_reset();
    s_reset();
    s_cmd();
    s_hist();
    s_irq();
    s_run();
    s_abort();
    s_soft();
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
